// ---- bench/mgmt_host_checker.sv ----
// Purpose: frame field and timing checks on the serial pins
// Assumes: half_limit equals the one given to the design
// Notes: cnt counts clock rises since direction last rose
`timescale 1ns/1ns
module mgmt_host_checker #(
	parameter int half_limit = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// serial pins
	input wire logic serial_clock_bit,
	input wire logic serial_data_bit,
	input wire logic drive_direction_bit
);
	logic [7:0] lo;
	logic [7:0] hi;
	logic [7:0] cnt;
	logic ck_q;
	logic dir_q;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// phase lengths and rise count
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lo <= 8'h00;
			hi <= 8'h00;
			cnt <= 8'h00;
			ck_q <= 1'b0;
			dir_q <= 1'b0;
		end
		else
		begin
			ck_q <= serial_clock_bit;
			dir_q <= drive_direction_bit;
			lo <= serial_clock_bit ? 8'h00 : lo + {7'h0, lo != 8'hff};
			hi <= !serial_clock_bit ? 8'h00 : hi + {7'h0, hi != 8'hff};
			if (drive_direction_bit && !dir_q)
				cnt <= 8'h00;
			else if (serial_clock_bit && !ck_q)
				cnt <= cnt + 8'h01;
		end
	end
	// falling clock while the host drives, after n bits
	sequence s_at(logic [7:0] n);
		$fell(serial_clock_bit) && drive_direction_bit && cnt == n;
	endsequence
	sequence s_pre;
		$fell(serial_clock_bit) && drive_direction_bit && cnt >= 8'h01 && cnt <= 8'h20;
	endsequence
	property p_preamble;
		s_pre |-> serial_data_bit;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble bit low");
	property p_start0;
		s_at(8'h21) |-> !serial_data_bit;
	endproperty
	a_start0: assert property (p_start0) else $error("start bit one wrong");
	property p_start1;
		s_at(8'h22) |-> serial_data_bit;
	endproperty
	a_start1: assert property (p_start1) else $error("start bit two wrong");
	property p_turn;
		s_at(8'h30) |-> !serial_data_bit;
	endproperty
	a_turn: assert property (p_turn) else $error("write turnaround wrong");
	property p_length;
		$fell(drive_direction_bit) |=> cnt == 8'h2f || cnt == 8'h41;
	endproperty
	a_length: assert property (p_length) else $error("release at wrong bit");
	property p_low;
		$rose(serial_clock_bit) |-> lo >= half_limit;
	endproperty
	a_low: assert property (p_low) else $error("clock low too short");
	property p_high;
		$fell(serial_clock_bit) |-> hi >= half_limit;
	endproperty
	a_high: assert property (p_high) else $error("clock high too short");
	property p_release;
		$fell(drive_direction_bit) |-> serial_clock_bit;
	endproperty
	a_release: assert property (p_release) else $error("release with clock low");
endmodule

bind mgmt_host mgmt_host_checker #(.half_limit(half_limit)) chk_u (.clock(clock), .rst_n(rst_n),
	.serial_clock_bit(serial_clock_bit), .serial_data_bit(serial_data_bit),
	.drive_direction_bit(drive_direction_bit));

// ---- bench/mgmt_host_tb.sv ----
// Purpose: self-checking bench for the management host
// Assumes: two phy models share the line with a bench pull level
// Notes: half and poll limits shortened to keep the run brief
`timescale 1ns/1ns
module mgmt_host_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic pull = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, sclk, sdo, sdir, d0, d1, o0, o1;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, got, st;
	logic [15:0] adv, par;
	int n_mismatch = 0;
	int tests_run = 0;
	int seed = 32'h3b2b;
	wire logic line;
	// wire level from all drivers, pulled when released
	assign line = sdir ? ((d0 | d1) ? 1'bx : sdo) : d0 ? o0 : d1 ? o1 : pull;
	always #10 clock = ~clock;
	mgmt_host #(.poll_limit(5000), .half_limit(4)) dut_u (.clock(clock), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .serial_clock_bit(sclk), .serial_data_bit(sdo),
		.drive_direction_bit(sdir), .serial_data_in(line));
	phy_model #(.phy_addr(5'h18)) int_u (.sclk(sclk), .line(line), .drv(d0), .dout(o0));
	phy_model #(.phy_addr(5'h0b)) ext_u (.sclk(sclk), .line(line), .drv(d1), .dout(o1));
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic run(input logic [2:0] c, input logic [4:0] p, input logic [4:0] r);
		int n;
		wr(mgmt_host_pkg::addr_command, {13'h0, c, 3'h0, p, 3'h0, r});
		n = 0;
		do
		begin
			rd(mgmt_host_pkg::addr_status);
			n++;
		end
		while (got[0] !== 1'b0 && n < 10000);
		if (n >= 10000)
			n_mismatch++;
		st = got;
	endtask
	function automatic logic [31:0] mode_of(input logic [15:0] a, input logic [15:0] p);
		mode_of = 32'h0;
		for (int i = 5; i <= 9; i++)
			if (a[i] && p[i])
				mode_of = 32'(i - 4);
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// cut a hang short, about one and three quarters times the expected run
	initial
	begin
		#1800000;
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rd(8'h1c);
		check({resp, got[29:0]}, {mgmt_host_pkg::resp_slverr, 30'h0});
		// unmapped write answers with an error response
		wr(8'h1c, 32'h0);
		check({30'h0, resp}, {30'h0, mgmt_host_pkg::resp_slverr});
		// random abilities written, local one read back, then probed
		for (int i = 0; i < 2; i++)
		begin
			adv = 16'($random(seed));
			par = i == 0 ? 16'($random(seed)) : ~adv;
			wr(mgmt_host_pkg::addr_write_data, {16'h0, adv});
			run(mgmt_host_pkg::cmd_write, 5'h18, mgmt_host_pkg::reg_local_ability);
			wr(mgmt_host_pkg::addr_write_data, {16'h0, par});
			run(mgmt_host_pkg::cmd_write, 5'h18, mgmt_host_pkg::reg_partner_ability);
			run(mgmt_host_pkg::cmd_read, 5'h18, mgmt_host_pkg::reg_local_ability);
			check({31'h0, st[2]}, 32'h0);
			rd(mgmt_host_pkg::addr_read_data);
			check(got, {16'h0, adv});
			run(mgmt_host_pkg::cmd_probe, 5'h18, 5'h00);
			check({31'h0, st[1]}, {31'h0, mode_of(adv, par) == 32'h0});
			rd(mgmt_host_pkg::addr_result);
			check(got, mode_of(adv, par));
		end
		// nobody at address 07, then a scan finds only the phy at 0b
		run(mgmt_host_pkg::cmd_read, 5'h07, mgmt_host_pkg::reg_control);
		check({31'h0, st[2]}, 32'h1);
		run(mgmt_host_pkg::cmd_probe, 5'h07, 5'h00);
		check({31'h0, st[1]}, 32'h1);
		run(mgmt_host_pkg::cmd_scan, 5'h00, 5'h00);
		check({31'h0, st[1]}, 32'h0);
		rd(mgmt_host_pkg::addr_found);
		check(got, 32'h800);
		// detect follows the released line
		for (int i = 0; i < 2; i++)
		begin
			pull <= 1'(i);
			run(mgmt_host_pkg::cmd_detect, 5'h00, 5'h00);
			check({31'h0, st[3]}, 32'(i));
		end
		finish_test();
	end
endmodule

// ---- bench/phy_model.sv ----
// Purpose: managed phy register set answering serial frames
// Assumes: bit k is read at the clock fall of bit k plus one
// Notes: reset and restart stay busy for slow reads
`timescale 1ns/1ns
module phy_model #(
	parameter logic [4:0] phy_addr = 5'h18,
	parameter int slow = 2
) (
	// serial side
	input wire logic sclk,
	input wire logic line,
	// line driver
	output logic drv,
	output logic dout
);
	logic [15:0] regs [0:31];
	logic [15:0] q = 16'h0000;
	logic [12:0] hdr = 13'h0000;
	logic [15:0] sh = 16'h0000;
	logic rd = 1'b0;
	logic hit = 1'b0;
	int ones = 0;
	int pos = 0;
	int rst_left = 0;
	int neg_left = 1;
	// register defaults, negotiation capable
	initial
	begin
		foreach (regs[i])
			regs[i] = 16'h0000;
		regs[1] = 16'h0029;
		drv = 1'b0;
		dout = 1'b1;
	end
	// decode one bit per fall, then drive claim and data
	always @(negedge sclk)
	begin
		if (pos == 0)
		begin
			if (!line && ones >= 32)
				pos = 1;
			ones = line ? ones + 1 : 0;
		end
		else
		begin
			pos = pos + 1;
			hdr = pos <= 14 ? {hdr[11:0], line} : hdr;
			sh = {sh[14:0], line};
			rd = pos == 14 ? hdr[11:10] == 2'h2 : rd;
			hit = pos == 14 ? hdr[9:5] == phy_addr : hit;
			if (pos == 32 && hit && !rd)
			begin
				regs[hdr[4:0]] = sh;
				if (hdr[4:0] == 5'h00)
				begin
					rst_left = sh[15] ? slow : 0;
					neg_left = sh[9] ? slow : neg_left;
					regs[0] = sh & 16'h7dff;
				end
			end
			pos = pos == 32 ? 0 : pos;
		end
		if (pos == 15)
		begin
			q = regs[hdr[4:0]];
			if (rd && hit && hdr[4:0] == 5'h00 && rst_left > 0)
			begin
				q[15] = 1'b1;
				rst_left = rst_left - 1;
			end
			if (rd && hit && hdr[4:0] == 5'h01 && neg_left > 0)
			begin
				q[5] = 1'b0;
				neg_left = neg_left - 1;
			end
		end
		drv = rd && hit && pos >= 15 && pos <= 31;
		dout = pos == 15 ? 1'b0 : q[4'(31 - pos)];
	end
endmodule

// ---- inc/mgmt_host_pkg.sv ----
// Purpose: constants for the serial management host controller
// Assumes: 50 MHz system clock, AXI4-Lite register port
// Notes: register offsets are byte addresses of aligned words
//
// Contract
// - every frame opens with thirty-two one bits of preamble
// - start 01, opcode 10 read or 01 write, then phy and register address
// - read: drive line, shift preamble through register address, one bit per cycle
// - after one z cycle the phy drives zero; a one means no answer
// - read sixteen data bits, bit 15 first, bit 0 last
// - write: drive line, shift six fields including turnaround 10
// - write sixteen data bits msb first; every frame ends with a z cycle
// - read cycle: clock low 200 ns, high 200 ns, sample, wait 200 ns
// - write cycle: clock low 200 ns, high with data, wait 200 ns
// - z cycle: clock low, high, release line, wait 200 ns
// - detect external phy: release line, read data bit, one means present
// - scan addresses 0 to 31 except 11000b, record responders, fail if none
// - probe: reset phy, poll reset bit, fail after 2 s or second read set
// - capable but incomplete: set restart, poll completion up to 2 s
// - choose highest common bit 5..9 of local and partner ability, else fail
package mgmt_host_pkg;
	localparam int clock_mhz = 50;
	localparam int half_time_ns = 200;
	localparam int half_cycles = (half_time_ns * clock_mhz + 999) / 1000;
	localparam longint poll_time_ms = 2000;
	localparam int poll_cycles = int'(poll_time_ms * 1000 * clock_mhz);
	localparam int preamble_bits = 32;
	localparam int data_bits = 16;
	localparam logic [1:0] start_code = 2'h1;
	localparam logic [1:0] op_read = 2'h2;
	localparam logic [1:0] op_write = 2'h1;
	localparam logic [1:0] turn_write = 2'h2;
	localparam logic [4:0] internal_phy = 5'h18;
	localparam logic [4:0] reg_control = 5'h00;
	localparam logic [4:0] reg_status = 5'h01;
	localparam logic [4:0] reg_local_ability = 5'h04;
	localparam logic [4:0] reg_partner_ability = 5'h05;
	localparam int bit_reset = 15;
	localparam int bit_restart = 9;
	localparam int bit_done = 5;
	localparam int bit_capable = 3;
	localparam int bit_extended = 0;
	localparam int mode_low = 5;
	localparam int mode_high = 9;
	// register offsets
	localparam logic [7:0] addr_command = 8'h00;
	localparam logic [7:0] addr_write_data = 8'h04;
	localparam logic [7:0] addr_status = 8'h08;
	localparam logic [7:0] addr_read_data = 8'h0c;
	localparam logic [7:0] addr_result = 8'h10;
	localparam logic [7:0] addr_found = 8'h14;
	// command codes in command[18:16]
	localparam logic [2:0] cmd_read = 3'h1;
	localparam logic [2:0] cmd_write = 3'h2;
	localparam logic [2:0] cmd_detect = 3'h3;
	localparam logic [2:0] cmd_scan = 3'h4;
	localparam logic [2:0] cmd_probe = 3'h5;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef enum logic [3:0] {
		st_idle = 4'h0, st_frame = 4'h1, st_done_frame = 4'h3, st_scan = 4'h2,
		st_reset_wr = 4'h6, st_reset_poll = 4'h7, st_status = 4'h5, st_restart = 4'h4,
		st_poll_done = 4'hc, st_adv = 4'hd, st_partner = 4'hf, st_finish = 4'he
	} seq_type;
endpackage

// ---- rtl/mgmt_host.sv ----
// Purpose: host controller that runs management frames and the phy probe sequence
// Assumes: AXI4-Lite slave port on clock, serial pins of the managed device
// Notes: one bit cycle is low, high and settle phases of half_cycles each
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module mgmt_host #(
	parameter int poll_limit = mgmt_host_pkg::poll_cycles,
	parameter int half_limit = mgmt_host_pkg::half_cycles
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// axi4-lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// device serial control bits
	output logic serial_clock_bit,
	output logic serial_data_bit,
	output logic drive_direction_bit,
	input wire logic serial_data_in
);
	// register state
	logic [31:0] command;
	logic [15:0] write_data;
	logic [15:0] read_data;
	logic [31:0] found;
	logic busy;
	logic fail;
	logic no_answer;
	logic present;
	logic [2:0] link_mode;
	logic start_pulse;
	// frame engine state
	mgmt_host_pkg::seq_type seq;
	logic frame_go;
	logic frame_active;
	logic frame_read;
	logic [4:0] frame_phy;
	logic [4:0] frame_reg;
	logic [15:0] frame_wdata;
	logic [6:0] bit_index;
	logic [1:0] phase;
	logic [15:0] half_count;
	logic [63:0] shift_out;
	logic [16:0] shift_in;
	logic data_sync1;
	logic data_sync2;
	logic [31:0] poll_count;
	logic [5:0] scan_phy;
	logic [15:0] local_ability;
	logic aw_taken;
	logic w_taken;
	logic [7:0] aw_hold;
	logic [31:0] w_hold;

	// highest common link mode bit
	function automatic logic [2:0] pick_mode(input logic [15:0] a, input logic [15:0] b);
		logic [2:0] m;
		m = 3'h0;
		for (int i = mgmt_host_pkg::mode_low; i <= mgmt_host_pkg::mode_high; i++)
		begin
			if (a[i] && b[i])
				m = 3'(i - mgmt_host_pkg::mode_low + 1);
		end
		return m;
	endfunction

	// data line input synchroniser
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_sync1 <= 1'b0;
			data_sync2 <= 1'b0;
		end
		else
		begin
			data_sync1 <= serial_data_in;
			data_sync2 <= data_sync1;
		end
	end

	// axi write channel with independent address and data acceptance
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_taken <= 1'b0;
			w_taken <= 1'b0;
			aw_hold <= 8'h00;
			w_hold <= 32'h0;
			bvalid <= 1'b0;
			bresp <= mgmt_host_pkg::resp_okay;
			command <= 32'h0;
			write_data <= 16'h0000;
			start_pulse <= 1'b0;
		end
		else
		begin
			start_pulse <= 1'b0;
			if (awvalid && awready)
			begin
				aw_hold <= awaddr;
				aw_taken <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_hold <= wdata;
				w_taken <= 1'b1;
				wready <= 1'b0;
			end
			if (aw_taken && w_taken && !bvalid)
			begin
				bvalid <= 1'b1;
				bresp <= mgmt_host_pkg::resp_okay;
				if (aw_hold == mgmt_host_pkg::addr_command)
				begin
					if (!busy && wstrb != 4'h0)
					begin
						command <= w_hold;
						start_pulse <= 1'b1;
					end
				end
				else if (aw_hold == mgmt_host_pkg::addr_write_data)
					write_data <= w_hold[15:0];
				else
					bresp <= mgmt_host_pkg::resp_slverr;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				aw_taken <= 1'b0;
				w_taken <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// axi read channel
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= mgmt_host_pkg::resp_okay;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= mgmt_host_pkg::resp_okay;
			if (araddr == mgmt_host_pkg::addr_command)
				rdata <= command;
			else if (araddr == mgmt_host_pkg::addr_write_data)
				rdata <= {16'h0000, write_data};
			else if (araddr == mgmt_host_pkg::addr_status)
				rdata <= {28'h0, present, no_answer, fail, busy};
			else if (araddr == mgmt_host_pkg::addr_read_data)
				rdata <= {16'h0000, read_data};
			else if (araddr == mgmt_host_pkg::addr_result)
				rdata <= {29'h0, link_mode};
			else if (araddr == mgmt_host_pkg::addr_found)
				rdata <= found;
			else
			begin
				rdata <= 32'h0;
				rresp <= mgmt_host_pkg::resp_slverr;
			end
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// bit engine: one bit cycle is low, high then settle, each half_limit long
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_active <= 1'b0;
			bit_index <= 7'h00;
			phase <= 2'h0;
			half_count <= 16'h0000;
			shift_out <= 64'h0;
			shift_in <= 17'h00000;
			serial_clock_bit <= 1'b0;
			serial_data_bit <= 1'b1;
			drive_direction_bit <= 1'b0;
		end
		else if (frame_go && !frame_active)
		begin
			frame_active <= 1'b1;
			bit_index <= 7'h00;
			phase <= 2'h0;
			half_count <= 16'h0000;
			drive_direction_bit <= 1'b1;
			shift_out <= {32'hffffffff, mgmt_host_pkg::start_code,
				frame_read ? mgmt_host_pkg::op_read : mgmt_host_pkg::op_write,
				frame_phy, frame_reg, mgmt_host_pkg::turn_write, frame_wdata};
		end
		else if (frame_active)
		begin
			if (half_count != 16'(half_limit - 1))
				half_count <= half_count + 16'h0001;
			else
			begin
				half_count <= 16'h0000;
				phase <= phase + 2'h1;
				if (phase == 2'h0)
					serial_clock_bit <= 1'b0;
				else if (phase == 2'h1)
				begin
					serial_clock_bit <= 1'b1;
					// write bits go out with the rising clock
					if (drive_direction_bit && bit_index < 7'd64)
					begin
						serial_data_bit <= shift_out[63];
						shift_out <= {shift_out[62:0], 1'b0};
					end
					// the z cycle releases the line on the same clock edge that raises the serial clock
					if ((frame_read && bit_index == 7'd46) || bit_index == 7'd64
						|| (frame_read && bit_index == 7'd64))
						drive_direction_bit <= 1'b0;
				end
				else
				begin
					phase <= 2'h0;
					// sample after high time, read cycles only
					if (frame_read && bit_index > 7'd46 && bit_index < 7'd64)
						shift_in <= {shift_in[15:0], data_sync2};
					if (bit_index == 7'd64)
					begin
						frame_active <= 1'b0;
						serial_data_bit <= 1'b1;
					end
					bit_index <= bit_index + 7'h01;
				end
			end
		end
	end

	// sequencer for frames, scan and probe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq <= mgmt_host_pkg::st_idle;
			busy <= 1'b0;
			fail <= 1'b0;
			no_answer <= 1'b0;
			present <= 1'b0;
			link_mode <= 3'h0;
			found <= 32'h0;
			read_data <= 16'h0000;
			frame_go <= 1'b0;
			frame_read <= 1'b1;
			frame_phy <= 5'h00;
			frame_reg <= 5'h00;
			frame_wdata <= 16'h0000;
			poll_count <= 32'h0;
			scan_phy <= 6'h00;
			local_ability <= 16'h0000;
		end
		else
		begin
			frame_go <= 1'b0;
			case (seq)
				mgmt_host_pkg::st_idle:
				if (start_pulse)
				begin
					busy <= 1'b1;
					fail <= 1'b0;
					frame_phy <= command[12:8];
					frame_reg <= command[4:0];
					frame_wdata <= write_data;
					poll_count <= 32'h0;
					if (command[18:16] == mgmt_host_pkg::cmd_read
						|| command[18:16] == mgmt_host_pkg::cmd_write)
					begin
						frame_read <= command[18:16] == mgmt_host_pkg::cmd_read;
						frame_go <= 1'b1;
						seq <= mgmt_host_pkg::st_frame;
					end
					else if (command[18:16] == mgmt_host_pkg::cmd_detect)
					begin
						present <= data_sync2;
						busy <= 1'b0;
					end
					else if (command[18:16] == mgmt_host_pkg::cmd_scan)
					begin
						found <= 32'h0;
						scan_phy <= 6'h00;
						seq <= mgmt_host_pkg::st_scan;
					end
					else if (command[18:16] == mgmt_host_pkg::cmd_probe)
					begin
						frame_read <= 1'b0;
						frame_reg <= mgmt_host_pkg::reg_control;
						frame_wdata <= 16'h8000;
						frame_go <= 1'b1;
						seq <= mgmt_host_pkg::st_reset_wr;
					end
					else
						busy <= 1'b0;
				end
				mgmt_host_pkg::st_frame:
				if (!frame_go && !frame_active)
				begin
					read_data <= shift_in[15:0];
					no_answer <= frame_read & shift_in[16];
					busy <= 1'b0;
					seq <= mgmt_host_pkg::st_idle;
				end
				mgmt_host_pkg::st_scan:
				if (scan_phy[5])
				begin
					fail <= found == 32'h0;
					busy <= 1'b0;
					seq <= mgmt_host_pkg::st_idle;
				end
				else if (scan_phy[4:0] == mgmt_host_pkg::internal_phy)
					scan_phy <= scan_phy + 6'h01;
				else
				begin
					frame_read <= 1'b1;
					frame_phy <= scan_phy[4:0];
					frame_reg <= mgmt_host_pkg::reg_control;
					frame_go <= 1'b1;
					seq <= mgmt_host_pkg::st_done_frame;
				end
				mgmt_host_pkg::st_done_frame:
				if (!frame_go && !frame_active)
				begin
					found[scan_phy[4:0]] <= ~shift_in[16];
					scan_phy <= scan_phy + 6'h01;
					seq <= mgmt_host_pkg::st_scan;
				end
				mgmt_host_pkg::st_reset_wr:
				if (!frame_go && !frame_active)
				begin
					frame_read <= 1'b1;
					frame_go <= 1'b1;
					seq <= mgmt_host_pkg::st_reset_poll;
				end
				mgmt_host_pkg::st_reset_poll:
				begin
					poll_count <= poll_count + 32'h1;
					if (!frame_go && !frame_active)
					begin
						if (!shift_in[mgmt_host_pkg::bit_reset])
						begin
							// second read confirms the self-clearing reset bit
							frame_go <= 1'b1;
							seq <= mgmt_host_pkg::st_status;
						end
						else if (poll_count >= 32'(poll_limit))
							seq <= mgmt_host_pkg::st_finish;
						else
							frame_go <= 1'b1;
					end
				end
				mgmt_host_pkg::st_status:
				if (!frame_go && !frame_active)
				begin
					// reset bit only means something in the control word
					if (frame_reg == mgmt_host_pkg::reg_control)
					begin
						if (shift_in[mgmt_host_pkg::bit_reset])
							seq <= mgmt_host_pkg::st_finish;
						else
						begin
							frame_reg <= mgmt_host_pkg::reg_status;
							frame_go <= 1'b1;
						end
					end
					else if (!shift_in[mgmt_host_pkg::bit_extended]
						|| !shift_in[mgmt_host_pkg::bit_capable])
						seq <= mgmt_host_pkg::st_finish;
					else if (shift_in[mgmt_host_pkg::bit_done])
					begin
						frame_reg <= mgmt_host_pkg::reg_local_ability;
						frame_go <= 1'b1;
						seq <= mgmt_host_pkg::st_adv;
					end
					else
					begin
						frame_read <= 1'b0;
						frame_reg <= mgmt_host_pkg::reg_control;
						frame_wdata <= 16'h0200;
						frame_go <= 1'b1;
						poll_count <= 32'h0;
						seq <= mgmt_host_pkg::st_restart;
					end
				end
				mgmt_host_pkg::st_restart:
				if (!frame_go && !frame_active)
				begin
					frame_read <= 1'b1;
					frame_reg <= mgmt_host_pkg::reg_status;
					frame_go <= 1'b1;
					seq <= mgmt_host_pkg::st_poll_done;
				end
				mgmt_host_pkg::st_poll_done:
				begin
					poll_count <= poll_count + 32'h1;
					if (!frame_go && !frame_active)
					begin
						if (shift_in[mgmt_host_pkg::bit_done])
						begin
							frame_reg <= mgmt_host_pkg::reg_local_ability;
							frame_go <= 1'b1;
							seq <= mgmt_host_pkg::st_adv;
						end
						else if (poll_count >= 32'(poll_limit))
							seq <= mgmt_host_pkg::st_finish;
						else
							frame_go <= 1'b1;
					end
				end
				mgmt_host_pkg::st_adv:
				if (!frame_go && !frame_active)
				begin
					local_ability <= shift_in[15:0];
					frame_reg <= mgmt_host_pkg::reg_partner_ability;
					frame_go <= 1'b1;
					seq <= mgmt_host_pkg::st_partner;
				end
				mgmt_host_pkg::st_partner:
				if (!frame_go && !frame_active)
				begin
					link_mode <= pick_mode(local_ability, shift_in[15:0]);
					fail <= pick_mode(local_ability, shift_in[15:0]) == 3'h0;
					busy <= 1'b0;
					seq <= mgmt_host_pkg::st_idle;
				end
				default:
				begin
					fail <= 1'b1;
					link_mode <= 3'h0;
					busy <= 1'b0;
					seq <= mgmt_host_pkg::st_idle;
				end
			endcase
		end
	end
endmodule
